// File: rtl/usas_defines.svh
// Register offsets, field positions, reset values for the address/stall/status block
// Assumes byte addressing on APB, one aligned 32-bit word per register
`ifndef USAS_DEFINES_SVH
`define USAS_DEFINES_SVH
// Register indices; the byte address on the bus is four times the index
`define USAS_IDX_ADDR 8'h23
`define USAS_IDX_HALT 8'h24
`define USAS_IDX_STAT 8'h25
`define USAS_IDX_IRQ_ST 8'h30
`define USAS_IDX_IRQ_EN 8'h31
`define USAS_IDX_IRQ_CLR 8'h32
// Address register fields
`define USAS_WAKE_BIT 0
`define USAS_ADDR_LSB 1
`define USAS_ADDR_RST 8'h00
// Status bit positions
`define USAS_ST_DEFER 0
`define USAS_ST_ERR 1
`define USAS_ST_OUT 2
`define USAS_ST_IN 3
`define USAS_ST_NAK 4
`define USAS_ST_CRC 5
`define USAS_ST_EOT 6
`define USAS_ST_NAKMSK 7
`define USAS_STAT_RST 8'h40
// Status bits firmware may write (defer, err, out, crc, mask)
`define USAS_STAT_WMASK 8'hA7
// Firmware clearable only (err, out, crc)
`define USAS_STAT_CMASK 8'h26
// Number of endpoints with halt bits
`define USAS_NUM_EP 3
// Interrupt event bits: nak, out, err, crc
`define USAS_NUM_IRQ 4
`endif

// File: rtl/usas_pkg.sv
// Types shared by the address/stall/status block
// Assumes the defines header is compiled first
package usas_pkg;
	typedef logic [7:0] usas_byte_t;
	typedef enum logic [1:0]
	{
		USAS_ADR_IDLE = 2'b00,
		USAS_ADR_WAIT = 2'b01
	} usas_adr_e;
endpackage

// File: rtl/usas_apb_slave.sv
// APB slave front end: decodes the byte address to a register index and strobes
// Assumes a single clock and APB master driving signals after rising edges
`timescale 1ns/1ps
`default_nettype none
module usas_apb_slave
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// APB
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	// Decoded access
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] idx_out,
	output logic hit_out
);
	logic [9:0] word_idx;
	// Access phase strobes, decoded combinationally in the same cycle
	always_comb
	begin
		word_idx = paddr_in[11:2];
		idx_out = word_idx[7:0];
		hit_out = (word_idx[9:8] == 2'b00) && (paddr_in[1:0] == 2'b00);
		wr_out = psel_in && penable_in && pwrite_in;
		rd_out = psel_in && penable_in && !pwrite_in;
	end
endmodule // usas_apb_slave
`default_nettype wire

// File: rtl/usas_sticky.sv
// Sticky event bits with write-one-to-clear and enable gating
// Set wins over clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module usas_sticky
#(
	parameter int N = 4
)
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Events and software control
	input wire logic [N-1:0] set_in,
	input wire logic [N-1:0] clr_in,
	input wire logic [N-1:0] en_in,
	// State
	output logic [N-1:0] stat_out,
	output logic irq_out
);
	logic [N-1:0] stat_q;
	logic [N-1:0] stat_d;
	logic irq_q;
	logic irq_d;
	// Next state per bit
	always_comb
	begin
		stat_d = (stat_q & ~clr_in) | set_in;
		irq_d = |(stat_d & en_in);
	end
	// Registers
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			stat_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			stat_q <= stat_d;
			irq_q <= irq_d;
		end
	end
	assign stat_out = stat_q;
	assign irq_out = irq_q;
endmodule // usas_sticky
`default_nettype wire

// File: rtl/usas_core.sv
// Address, remote-wake, endpoint halt and transaction status of a USB engine
// Assumes token/handshake events as one-cycle pulses synchronous to ref_clk_in
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "usas_defines.svh"
//
// Operation
// - Endpoint 2 FIFO is hardware-only; no register reaches its data.
// - Address register holds wake bit 0, address bits 1..7; resets to zero.
// - Wake enable output follows address register bit 0.
// - Halt bits 0..2 set by firmware; cleared by USB reset and SETUP token.
// - Halt register bits 3..7 always read zero.
// - With deferred bit set, active address changes after a good IN read.
// - With deferred bit clear, active address changes at the register write.
// - Endpoint 0 FIFO error sets status bit 1; firmware clears it.
// - Non-empty OUT sets bit 2; firmware or valid SETUP clears it.
// - Read-only bit 3 shows the current token is IN.
// - Read-only bit 4 shows a NAK was sent for IN or OUT.
// - CRC, PID or incomplete token sets bit 5; firmware clears it.
// - Read-only bit 6 resets high and is low during a token.
// - Bit 7 set masks NAK interrupts; clear lets each NAK interrupt.
module usas_core
import usas_pkg::*;
#(
	parameter int NUM_EP = `USAS_NUM_EP
)
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Engine events
	input wire logic usb_reset_in,
	input wire logic setup_tok_in,
	input wire logic in_tok_in,
	input wire logic out_data_in,
	input wire logic in_done_in,
	input wire logic nak_sent_in,
	input wire logic ep0_err_in,
	input wire logic pkt_err_in,
	input wire logic tok_active_in,
	input wire logic [1:0] tok_ep_in,
	// Engine controls
	output logic [6:0] device_address_field_out,
	output logic remote_wake_enable_out,
	output logic stall_reply_out,
	output logic irq_out
);
	logic wr_raw;
	logic wr;
	logic rd;
	logic rd_pend_q, rd_pend_d;
	logic hit;
	logic [7:0] idx;
	usas_byte_t wdat;
	usas_byte_t addr_q, addr_d;
	logic [6:0] act_q, act_d;
	usas_adr_e adr_q, adr_d;
	logic [NUM_EP-1:0] halt_q, halt_d;
	usas_byte_t stat_q, stat_d;
	logic wake_q, wake_d;
	logic stall_q, stall_d;
	logic [31:0] rdata_q, rdata_d;
	logic err_q, err_d;
	logic [`USAS_NUM_IRQ-1:0] ien_q, ien_d;
	logic [`USAS_NUM_IRQ-1:0] iclr;
	logic [`USAS_NUM_IRQ-1:0] iset;
	logic [`USAS_NUM_IRQ-1:0] ist;
	logic irq_w;

	// Bus decode
	usas_apb_slave u_apb
	(
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.psel_in(psel_in),
		.penable_in(penable_in),
		.pwrite_in(pwrite_in),
		.paddr_in(paddr_in),
		.wr_out(wr_raw),
		.rd_out(rd),
		.idx_out(idx),
		.hit_out(hit)
	);
	assign wdat = pwdata_in[7:0];
	// Writes land only at the edge where ready is high, so an engine set in
	// the wait cycle is never undone by a second pass of the same clear
	assign wr = wr_raw && rd_pend_q;

	// Events: nak (unless masked), out, ep0 error, packet error
	always_comb
	begin
		iset = {pkt_err_in, ep0_err_in, out_data_in,
			nak_sent_in && !stat_q[`USAS_ST_NAKMSK]};
		iclr = (wr && hit && idx == `USAS_IDX_IRQ_CLR) ? wdat[`USAS_NUM_IRQ-1:0] : '0;
	end

	// Sticky interrupt bits; set beats a same-cycle clear
	usas_sticky #(.N(`USAS_NUM_IRQ)) u_irq
	(
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.set_in(iset),
		.clr_in(iclr),
		.en_in(ien_q),
		.stat_out(ist),
		.irq_out(irq_w)
	);

	// Address register and active address tracking
	always_comb
	begin
		addr_d = addr_q;
		act_d = act_q;
		adr_d = adr_q;
		if (wr && hit && idx == `USAS_IDX_ADDR)
		begin
			addr_d = wdat;
			if (stat_q[`USAS_ST_DEFER])
				adr_d = USAS_ADR_WAIT;
			else
				act_d = wdat[7:`USAS_ADDR_LSB];
		end
		else if (adr_q == USAS_ADR_WAIT && in_done_in)
		begin
			act_d = addr_q[7:`USAS_ADDR_LSB];
			adr_d = USAS_ADR_IDLE;
		end
		if (usb_reset_in)
		begin
			addr_d = `USAS_ADDR_RST;
			act_d = '0;
			adr_d = USAS_ADR_IDLE;
		end
		wake_d = addr_d[`USAS_WAKE_BIT];
	end

	// Halt bits: software sets, reset and SETUP clear (clear wins, engine event)
	always_comb
	begin
		halt_d = halt_q;
		if (wr && hit && idx == `USAS_IDX_HALT)
			halt_d = wdat[NUM_EP-1:0];
		if (usb_reset_in || setup_tok_in)
			halt_d = '0;
		stall_d = tok_active_in && (int'(tok_ep_in) < NUM_EP) && halt_q[tok_ep_in];
	end

	// Status flags; hardware sets win over firmware clears
	always_comb
	begin
		stat_d = stat_q;
		if (wr && hit && idx == `USAS_IDX_STAT)
		begin
			// Writable bits take the value, sticky bits only accept clearing
			stat_d[`USAS_ST_DEFER] = wdat[`USAS_ST_DEFER];
			stat_d[`USAS_ST_NAKMSK] = wdat[`USAS_ST_NAKMSK];
			stat_d = stat_d & ~(`USAS_STAT_CMASK & ~wdat);
		end
		if (setup_tok_in)
			stat_d[`USAS_ST_OUT] = 1'b0;
		if (ep0_err_in)
			stat_d[`USAS_ST_ERR] = 1'b1;
		if (out_data_in)
			stat_d[`USAS_ST_OUT] = 1'b1;
		if (pkt_err_in)
			stat_d[`USAS_ST_CRC] = 1'b1;
		stat_d[`USAS_ST_IN] = in_tok_in;
		stat_d[`USAS_ST_NAK] = nak_sent_in ? 1'b1 : (tok_active_in ? stat_q[`USAS_ST_NAK] : 1'b0);
		stat_d[`USAS_ST_EOT] = !tok_active_in;
		if (usb_reset_in)
			stat_d = `USAS_STAT_RST;
	end

	// Interrupt enable and read mux; endpoint 2 data has no register
	always_comb
	begin
		ien_d = ien_q;
		if (wr && hit && idx == `USAS_IDX_IRQ_EN)
			ien_d = wdat[`USAS_NUM_IRQ-1:0];
		rdata_d = 32'h0000_0000;
		err_d = 1'b0;
		if ((rd || wr_raw) && !hit)
			err_d = 1'b1;
		else if (rd)
		begin
			unique case (idx)
				`USAS_IDX_ADDR: rdata_d[7:0] = addr_q;
				`USAS_IDX_HALT: rdata_d[NUM_EP-1:0] = halt_q;
				`USAS_IDX_STAT: rdata_d[7:0] = stat_q;
				`USAS_IDX_IRQ_ST: rdata_d[`USAS_NUM_IRQ-1:0] = ist;
				`USAS_IDX_IRQ_EN: rdata_d[`USAS_NUM_IRQ-1:0] = ien_q;
				default: err_d = 1'b1;
			endcase
		end
	end

	// State registers
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			addr_q <= `USAS_ADDR_RST;
			act_q <= '0;
			adr_q <= USAS_ADR_IDLE;
			halt_q <= '0;
			stat_q <= `USAS_STAT_RST;
			wake_q <= 1'b0;
			stall_q <= 1'b0;
			ien_q <= '0;
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end
		else
		begin
			addr_q <= addr_d;
			act_q <= act_d;
			adr_q <= adr_d;
			halt_q <= halt_d;
			stat_q <= stat_d;
			wake_q <= wake_d;
			stall_q <= stall_d;
			ien_q <= ien_d;
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	// Ready is registered, so every access gets one wait state; read data and
	// error are loaded on the first access edge and stand while ready is high
	always_comb
	begin
		rd_pend_d = psel_in && penable_in && !rd_pend_q;
	end
	// Ready register
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rd_pend_q <= 1'b0;
		else
			rd_pend_q <= rd_pend_d;
	end
	assign pready_out = rd_pend_q;
	assign prdata_out = rdata_q;
	assign pslverr_out = err_q;
	assign device_address_field_out = act_q;
	assign remote_wake_enable_out = wake_q;
	assign stall_reply_out = stall_q;
	assign irq_out = irq_w;

	// Checks: address register, wake-up and active address
	// Writes are gated by ready, so one request moves each register once
	chk_addr_rst: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		usb_reset_in |=> addr_q == 8'h00)
		else $error("addr not reset");
	chk_wake: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		wr && hit && idx == `USAS_IDX_ADDR && !usb_reset_in
		|=> remote_wake_enable_out == $past(wdat[`USAS_WAKE_BIT]))
		else $error("wake mismatch");
	chk_imm_addr: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		wr && hit && idx == `USAS_IDX_ADDR && !stat_q[`USAS_ST_DEFER] && !usb_reset_in
		|=> act_q == $past(wdat[7:1]))
		else $error("address not immediate");
	chk_def_addr: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		adr_q == USAS_ADR_WAIT && !in_done_in && !wr && !usb_reset_in
		|=> $stable(act_q))
		else $error("address moved early");
	chk_def_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		wr && hit && idx == `USAS_IDX_ADDR && stat_q[`USAS_ST_DEFER] && !usb_reset_in
		|=> $stable(device_address_field_out))
		else $error("deferred address applied at write");
	chk_def_apply: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		adr_q == USAS_ADR_WAIT && in_done_in && !wr && !usb_reset_in
		|=> device_address_field_out == $past(addr_q[7:1]))
		else $error("deferred address not applied");
	// Checks: halt bits and stall replies
	chk_halt_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(setup_tok_in || usb_reset_in) |=> halt_q == '0)
		else $error("halt not cleared");
	chk_halt_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		wr && hit && idx == `USAS_IDX_HALT && !usb_reset_in && !setup_tok_in
		|=> halt_q == $past(wdat[NUM_EP-1:0]))
		else $error("halt write lost");
	chk_halt_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		rd && hit && idx == `USAS_IDX_HALT |=> rdata_q[31:NUM_EP] == '0)
		else $error("halt upper bits");
	chk_stall_rep: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		tok_active_in && tok_ep_in == 2'd0 && halt_q[0] |=> stall_reply_out)
		else $error("no stall reply");
	chk_stall_idle: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!tok_active_in |=> !stall_reply_out)
		else $error("stall reply without token");
	// Checks: status flags; a hardware set must survive a same-cycle firmware clear
	chk_err_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ep0_err_in && !usb_reset_in |=> stat_q[`USAS_ST_ERR])
		else $error("err lost");
	chk_crc_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		pkt_err_in && !usb_reset_in |=> stat_q[`USAS_ST_CRC])
		else $error("crc lost");
	chk_out_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		out_data_in && !usb_reset_in |=> stat_q[`USAS_ST_OUT])
		else $error("out lost");
	chk_out_setup: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		setup_tok_in && !out_data_in |=> !stat_q[`USAS_ST_OUT])
		else $error("out not cleared");
	chk_in_flag: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		in_tok_in && !usb_reset_in |=> stat_q[`USAS_ST_IN])
		else $error("in flag");
	chk_nak_flag: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		nak_sent_in && !usb_reset_in |=> stat_q[`USAS_ST_NAK])
		else $error("nak flag");
	chk_nak_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!tok_active_in && !nak_sent_in |=> !stat_q[`USAS_ST_NAK])
		else $error("nak flag stuck");
	chk_eot_low: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		tok_active_in && !usb_reset_in |=> !stat_q[`USAS_ST_EOT])
		else $error("eot not low");
	chk_eot_idle: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!tok_active_in |=> stat_q[`USAS_ST_EOT])
		else $error("eot not high");
	chk_ro_bits: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		wr && hit && idx == `USAS_IDX_STAT && !tok_active_in && !usb_reset_in
		|=> stat_q[`USAS_ST_EOT])
		else $error("ro bit written");
	chk_ro_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		wr && hit && idx == `USAS_IDX_STAT && !usb_reset_in
		|=> stat_q[`USAS_ST_IN] == $past(in_tok_in))
		else $error("in bit written");
	// Checks: interrupts and bus answers
	chk_nak_mask: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		nak_sent_in && stat_q[`USAS_ST_NAKMSK] && ist[0] == 1'b0 && !iclr[0] |=> !ist[0])
		else $error("masked nak raised");
	chk_nak_irq: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		nak_sent_in && !stat_q[`USAS_ST_NAKMSK] |=> ist[0])
		else $error("unmasked nak lost");
	chk_irq_level: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		|(ist & ien_q) && iclr == '0 |=> irq_out)
		else $error("irq not raised");
	chk_irq_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ist == '0 && iset == '0 |=> !irq_out)
		else $error("irq without event");
	chk_unmapped: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		rd && hit && !(idx inside {`USAS_IDX_ADDR, `USAS_IDX_HALT, `USAS_IDX_STAT,
		`USAS_IDX_IRQ_ST, `USAS_IDX_IRQ_EN}) |=> pslverr_out && prdata_out == '0)
		else $error("unmapped read answered");
endmodule // usas_core
`default_nettype wire

// File: dv/usas_host_model.sv
// Far-side event source: bus reset, tokens and handshakes seen by the engine
// Assumes one bench process calls its tasks, between clock edges
`timescale 1ns/1ps
`default_nettype none
module usas_host_model
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Pulses: reset, setup, out, in_done, nak, ep0_err, pkt_err
	output logic [6:0] ev_out,
	// Token levels
	output logic in_tok_out,
	output logic tok_active_out,
	output logic [1:0] tok_ep_out
);
	// Quiet bus at time zero
	initial
	begin
		ev_out = 7'h00;
		in_tok_out = 1'b0;
		tok_active_out = 1'b0;
		tok_ep_out = 2'h0;
	end
	// One-cycle pulse on event k
	task automatic pulse(input int k);
		@(posedge ref_clk_in);
		ev_out[k] <= 1'b1;
		@(posedge ref_clk_in);
		ev_out <= 7'h00;
	endtask
	// Token start
	task automatic tok(input logic [1:0] ep, input logic is_in);
		@(posedge ref_clk_in);
		tok_active_out <= 1'b1;
		in_tok_out <= is_in;
		tok_ep_out <= ep;
	endtask
	// Token end; endpoint lines inverted so stale values never match
	task automatic idle();
		@(posedge ref_clk_in);
		tok_active_out <= 1'b0;
		in_tok_out <= 1'b0;
		tok_ep_out <= ~tok_ep_out;
	endtask
endmodule // usas_host_model
`default_nettype wire

// File: dv/usas_sie_address_stall_status_bench.sv
// Bench: APB master, integer model of the registers, host event model
// Assumes usas_core answers APB with a wait state and registered outputs
`timescale 1ns/1ps
`default_nettype none
`include "usas_defines.svh"
module usas_sie_address_stall_status_bench;
	import usas_pkg::*;
	logic clk, rst_n, psel, pen, pwr, in_tok, tok_act, wake, stall, irq, pready, pslverr, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, seed;
	logic [6:0] ev, dadr;
	logic [1:0] tok_ep;
	int err_total, checks, m_addr, m_halt, m_stat, m_ist, m_ien, m_act, m_in, m_tok, m_nak, m_ep;
	usas_core u_usas_core (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.usb_reset_in(ev[0]), .setup_tok_in(ev[1]), .in_tok_in(in_tok), .out_data_in(ev[2]),
		.in_done_in(ev[3]), .nak_sent_in(ev[4]), .ep0_err_in(ev[5]), .pkt_err_in(ev[6]),
		.tok_active_in(tok_act), .tok_ep_in(tok_ep), .device_address_field_out(dadr),
		.remote_wake_enable_out(wake), .stall_reply_out(stall), .irq_out(irq));
	usas_host_model u_usas_host_model (.ref_clk_in(clk), .rst_n_in(rst_n), .ev_out(ev),
		.in_tok_out(in_tok), .tok_active_out(tok_act), .tok_ep_out(tok_ep));
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Hang guard, far beyond the few hundred cycles needed
	initial
	begin
		#500000;
		err_total++;
		tally_and_finish();
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic cmp_reg(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic cmp_out(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", n, e, g);
		end
	endtask
	// One APB transfer; holds everything until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			err_total++;
			tally_and_finish();
		end
		q = prdata;
		se = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	function automatic int st();
		return m_stat | (m_in << 3) | (m_nak << 4) | ((m_tok == 0) << 6);
	endfunction
	task automatic rd(input logic [7:0] idx, input int e);
		apb(1'b0, idx, 32'h0);
		cmp_reg("rdata", e, q);
	endtask
	task automatic chk_outs();
		cmp_out("address", m_act, dadr);
		cmp_out("wake", m_addr & 1, wake);
		cmp_out("irq", (m_ist & m_ien) != 0, irq);
		if (m_tok)
			cmp_out("stall", (m_halt >> m_ep) & 1, stall);
	endtask
	// Register write plus model update
	task automatic mw(input logic [7:0] idx, input int d);
		apb(1'b1, idx, d);
		case (idx)
			`USAS_IDX_ADDR: m_addr = d & 8'hFF;
			`USAS_IDX_HALT: m_halt = d & 7;
			`USAS_IDX_STAT: m_stat = (d & 8'h81) | (m_stat & d & 8'h26);
			`USAS_IDX_IRQ_EN: m_ien = d & 4'hF;
			`USAS_IDX_IRQ_CLR: m_ist &= ~d;
			default: ;
		endcase
		if (idx == `USAS_IDX_ADDR && (m_stat & 1) == 0)
			m_act = m_addr >> 1;
		repeat (2) @(posedge clk);
		chk_outs();
	endtask
	// Host event plus model update
	task automatic ev_do(input int k);
		u_usas_host_model.pulse(k);
		case (k)
			0: {m_addr, m_halt, m_stat, m_act} = {32'd0, 32'd0, 32'd0, 32'd0};
			1: {m_halt, m_stat} = {32'd0, m_stat & ~4};
			2: {m_stat, m_ist} = {m_stat | 4, m_ist | 2};
			3: m_act = (m_stat & 1) ? m_addr >> 1 : m_act;
			4: {m_ist, m_nak} = {m_ist | ((m_stat & 8'h80) ? 0 : 1), m_tok};
			5: {m_stat, m_ist} = {m_stat | 2, m_ist | 4};
			default: {m_stat, m_ist} = {m_stat | 8'h20, m_ist | 8};
		endcase
		repeat (3) @(posedge clk);
		chk_outs();
	endtask
	task automatic tk(input int ep, input int in);
		u_usas_host_model.tok(ep, in);
		{m_tok, m_in, m_ep} = {32'd1, in, ep};
		repeat (3) @(posedge clk);
		chk_outs();
		rd(`USAS_IDX_STAT, st());
	endtask
	task automatic idl();
		u_usas_host_model.idle();
		{m_tok, m_in, m_nak} = {32'd0, 32'd0, 32'd0};
		repeat (3) @(posedge clk);
		rd(`USAS_IDX_STAT, st());
	endtask
	// Main sequence
	initial
	begin
		{psel, pen, pwr, paddr, pwdata, err_total, checks} = '0;
		{m_addr, m_halt, m_stat, m_ist, m_ien, m_act, m_in, m_tok, m_nak, m_ep} = '0;
		seed = 32'h57CA;
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(`USAS_IDX_ADDR, 0);
		rd(`USAS_IDX_HALT, 0);
		rd(`USAS_IDX_STAT, 8'h40);
		rd(`USAS_IDX_IRQ_EN, 0);
		rd(8'h3F, 0);
		cmp_reg("slverr", 1, se);
		// Address applied at once after the setup stage
		ev_do(1);
		for (int i = 0; i < 4; i++)
		begin
			seed = xs(seed);
			mw(`USAS_IDX_ADDR, seed[7:0]);
			rd(`USAS_IDX_ADDR, m_addr);
		end
		// Deferred address waits for the acknowledged IN read
		mw(`USAS_IDX_STAT, 1);
		mw(`USAS_IDX_ADDR, 8'h54);
		ev_do(3);
		ev_do(1);
		mw(`USAS_IDX_STAT, 0);
		// Halt bits
		mw(`USAS_IDX_HALT, 8'hFF);
		rd(`USAS_IDX_HALT, 7);
		ev_do(1);
		rd(`USAS_IDX_HALT, 0);
		mw(`USAS_IDX_HALT, 2);
		for (int ep = 0; ep < 3; ep++)
		begin
			tk(ep, ep & 1);
			idl();
		end
		// Status events and interrupts
		mw(`USAS_IDX_IRQ_EN, 8'h0F);
		tk(0, 1);
		ev_do(4);
		rd(`USAS_IDX_STAT, st());
		idl();
		ev_do(5);
		ev_do(2);
		ev_do(6);
		rd(`USAS_IDX_STAT, st());
		rd(`USAS_IDX_IRQ_ST, m_ist);
		mw(`USAS_IDX_STAT, 8'hFF);
		rd(`USAS_IDX_STAT, st());
		mw(`USAS_IDX_STAT, 8'h80);
		rd(`USAS_IDX_STAT, st());
		mw(`USAS_IDX_IRQ_CLR, 8'h0F);
		ev_do(4);
		rd(`USAS_IDX_IRQ_ST, m_ist);
		ev_do(2);
		ev_do(1);
		rd(`USAS_IDX_STAT, st());
		// Bus reset clears address and halt and returns status to 8'h40
		mw(`USAS_IDX_IRQ_EN, 0);
		mw(`USAS_IDX_HALT, 5);
		ev_do(0);
		rd(`USAS_IDX_ADDR, 0);
		rd(`USAS_IDX_HALT, 0);
		rd(`USAS_IDX_STAT, 8'h40);
		tally_and_finish();
	end
endmodule // usas_sie_address_stall_status_bench
`default_nettype wire
